// ==== pkg/vtp_pkg.sv ====
// vtp_pkg: constants, field layouts and carriers for the video test pattern generator.
// assumes one sample clock, an AXI4-Lite register port with 32-bit data and 8-bit addresses.
package vtp_pkg;

  // register byte offsets
  localparam logic [7:0] REG_CTRL      = 8'h00;
  localparam logic [7:0] REG_TBL_ADDR  = 8'h04;
  localparam logic [7:0] REG_TBL_DATA  = 8'h08;
  localparam logic [7:0] REG_GEN0_STAT = 8'h0c;
  localparam logic [7:0] REG_GEN1_STAT = 8'h10;

  // control register fields
  localparam int unsigned CTRL_SEL0_BIT     = 0;
  localparam int unsigned CTRL_SEL1_BIT     = 1;
  localparam int unsigned CTRL_RESTART0_BIT = 2;
  localparam int unsigned CTRL_RESTART1_BIT = 3;
  localparam int unsigned CTRL_NARROW_BIT   = 4;
  localparam logic [4:0]  CTRL_RESET        = 5'h00;

  // table address register fields
  localparam int unsigned TBL_IDX_W   = 11;
  localparam int unsigned TBL_SEL_LSB = 12;
  localparam logic [1:0]  TBL_COLUMN  = 2'h0;
  localparam logic [1:0]  TBL_ROW     = 2'h1;
  localparam logic [1:0]  TBL_SAMPLE  = 2'h2;

  // sample codes from the two low word-counter bits
  localparam logic [1:0] SC_CB   = 2'b00;
  localparam logic [1:0] SC_Y0   = 2'b01;
  localparam logic [1:0] SC_CR   = 2'b10;
  localparam logic [1:0] SC_SYNC = 2'b11;

  // fixed timing reference words
  localparam logic [9:0] TRS_FIRST = 10'h3ff;
  localparam logic [9:0] TRS_ZERO  = 10'h000;

  // checkfield levels (plain defaults)
  localparam logic [9:0] CF_A_LUMA   = 10'h198;
  localparam logic [9:0] CF_A_CHROMA = 10'h300;
  localparam logic [9:0] CF_B_LUMA   = 10'h110;
  localparam logic [9:0] CF_B_CHROMA = 10'h200;
  localparam logic [9:0] CF_MARK     = 10'h080;

  localparam logic [1:0] RESP_OKAY   = 2'b00;
  localparam logic [1:0] RESP_SLVERR = 2'b10;

  typedef struct packed {
    logic       sync_word_insert;
    logic       end_of_line;
    logic       line_blank_flag;
    logic [4:0] column_zone_code;
    logic [9:0] next_state;
  } vtp_col_word_t;

  typedef struct packed {
    logic       spare;
    logic       odd_even_marker;
    logic       frame_blank_flag;
    logic [4:0] row_zone_code;
    logic [9:0] next_state;
  } vtp_row_word_t;

  typedef struct packed {
    logic field;
    logic vblank;
    logic hblank;
  } vtp_fvh_t;

endpackage

// ==== hw/vtp_pattern_gen.sv ====
// vtp_pattern_gen: two table-driven 4:2:2 test pattern generators sharing one set of tables.
// assumes tables are loaded over AXI4-Lite before output is used; outputs feed an encoder.
// Operation
// - two-bit sample code, fourth value means sync
// - codes 01,11 luma; 00 blue; 10 red
// - sync insert swaps colour for field/blank bits
// - sync words 3ff, 000, 000, status word
// - checkfield: two patterns, field halves
// - first line last luma gets distinct value
// - checkfield from counters; bars keep sync/blanking
// - select input picks bars or checkfield
// - narrow variant uses eight colours only
// - two generators share tables, run independently
// - column table output register is state
// - column state advances every fourth clock
// - each column state spans four samples
// - column zone code four or five bits
// - column table gives blank flag, end-of-line
// - row table steps once per line
// - row table gives zone, field, blank
// - sample table addressed by code, zones, select
// - each generator selects pattern independently
// - duplicate table lsb into two low bits
// - field/blank bits delayed one clock; code delays them two clocks (fvh_q, then video_fvh)
//
// Added by the designer: the placing of the registers and the AXI4-Lite interface to the registers.
`timescale 1ns/100ps
module vtp_pattern_gen
  import vtp_pkg::*;
#(
  parameter int unsigned COL_ZONE_W      = 4,
  parameter int unsigned ROW_ZONE_W      = 4,
  parameter int unsigned CF_ACTIVE_WORDS = 1440,
  parameter int unsigned CF_HALF_LINES   = 122
) (
  input  wire logic                 mclk,          // sample clock
  input  wire logic                 rst_n,         // async reset
  input  wire logic [7:0]           s_axi_awaddr,  // write address
  input  wire logic                 s_axi_awvalid, // write address valid
  output logic                      s_axi_awready, // write address ready
  input  wire logic [31:0]          s_axi_wdata,   // write data
  input  wire logic [3:0]           s_axi_wstrb,   // byte enables
  input  wire logic                 s_axi_wvalid,  // write data valid
  output logic                      s_axi_wready,  // write data ready
  output logic [1:0]                s_axi_bresp,   // write response
  output logic                      s_axi_bvalid,  // write response valid
  input  wire logic                 s_axi_bready,  // write response ready
  input  wire logic [7:0]           s_axi_araddr,  // read address
  input  wire logic                 s_axi_arvalid, // read address valid
  output logic                      s_axi_arready, // read address ready
  output logic [31:0]               s_axi_rdata,   // read data
  output logic [1:0]                s_axi_rresp,   // read response
  output logic                      s_axi_rvalid,  // read data valid
  input  wire logic                 s_axi_rready,  // read data ready
  output logic [1:0][9:0]           video_data,    // per generator 10-bit word
  output vtp_pkg::vtp_fvh_t [1:0]   video_fvh      // per generator field/blank bits
);
  import vtp_pkg::*;

  // shared tables, one write port from software, one read port per generator
  logic [17:0] col_table [1024];
  logic [17:0] row_table [1024];
  logic [8:0]  val_table [2048];

  logic [7:0]  aw_addr;
  logic        aw_held;
  logic [31:0] w_data;
  logic [3:0]  w_strb;
  logic        w_held;
  logic        wr_fire;
  logic [1:0]  ctrl_sel;
  logic        ctrl_narrow;
  logic [1:0]  restart;
  logic [1:0]  tbl_sel;
  logic [10:0] tbl_idx;
  logic [31:0] tbl_addr_wr;
  logic [1:0][22:0] gen_status;

  function automatic logic [31:0] merge(input logic [31:0] old, input logic [31:0] nw,
                                        input logic [3:0] strb);
    logic [31:0] r;
    r = old;
    for (int i = 0; i < 4; i++) begin
      if (strb[i]) begin
        r[i*8 +: 8] = nw[i*8 +: 8];
      end
    end
    return r;
  endfunction

  function automatic logic mapped(input logic [7:0] a);
    return (a == REG_CTRL) || (a == REG_TBL_ADDR) || (a == REG_TBL_DATA) ||
           (a == REG_GEN0_STAT) || (a == REG_GEN1_STAT);
  endfunction

  // -------- AXI4-Lite write path --------
  assign s_axi_awready = !aw_held && !s_axi_bvalid;
  assign s_axi_wready  = !w_held && !s_axi_bvalid;
  assign wr_fire       = aw_held && w_held && !s_axi_bvalid;

  always_ff @(posedge mclk or negedge rst_n) begin
    if (!rst_n) begin
      aw_held <= 1'b0;
      aw_addr <= 8'h00;
    end else if (s_axi_awvalid && s_axi_awready) begin
      aw_held <= 1'b1;
      aw_addr <= {s_axi_awaddr[7:2], 2'b00};
    end else if (wr_fire) begin
      aw_held <= 1'b0;
    end
  end

  always_ff @(posedge mclk or negedge rst_n) begin
    if (!rst_n) begin
      w_held <= 1'b0;
      w_data <= 32'h0000_0000;
      w_strb <= 4'h0;
    end else if (s_axi_wvalid && s_axi_wready) begin
      w_held <= 1'b1;
      w_data <= s_axi_wdata;
      w_strb <= s_axi_wstrb;
    end else if (wr_fire) begin
      w_held <= 1'b0;
    end
  end

  always_ff @(posedge mclk or negedge rst_n) begin
    if (!rst_n) begin
      s_axi_bvalid <= 1'b0;
      s_axi_bresp  <= RESP_OKAY;
    end else if (wr_fire) begin
      s_axi_bvalid <= 1'b1;
      s_axi_bresp  <= mapped(aw_addr) ? RESP_OKAY : RESP_SLVERR;
    end else if (s_axi_bready) begin
      s_axi_bvalid <= 1'b0;
    end
  end

  // control: pattern selects, narrow palette, one-cycle restart pulses
  always_ff @(posedge mclk or negedge rst_n) begin
    if (!rst_n) begin
      ctrl_sel    <= CTRL_RESET[1:0];
      ctrl_narrow <= CTRL_RESET[CTRL_NARROW_BIT];
      restart     <= 2'b00;
    end else begin
      restart <= 2'b00;
      if (wr_fire && aw_addr == REG_CTRL && w_strb[0]) begin
        ctrl_sel    <= {w_data[CTRL_SEL1_BIT], w_data[CTRL_SEL0_BIT]};
        ctrl_narrow <= w_data[CTRL_NARROW_BIT];
        restart     <= {w_data[CTRL_RESTART1_BIT], w_data[CTRL_RESTART0_BIT]};
      end
    end
  end

  // table pointer, advancing after each data write
  assign tbl_addr_wr = merge({18'h0, tbl_sel, 1'b0, tbl_idx}, w_data, w_strb);

  always_ff @(posedge mclk or negedge rst_n) begin
    if (!rst_n) begin
      tbl_sel <= TBL_COLUMN;
      tbl_idx <= 11'h000;
    end else if (wr_fire && aw_addr == REG_TBL_ADDR) begin
      tbl_sel <= tbl_addr_wr[TBL_SEL_LSB +: 2];
      tbl_idx <= tbl_addr_wr[TBL_IDX_W-1:0];
    end else if (wr_fire && aw_addr == REG_TBL_DATA) begin
      tbl_idx <= tbl_idx + 11'h001;
    end
  end

  always_ff @(posedge mclk) begin
    if (wr_fire && aw_addr == REG_TBL_DATA) begin
      case (tbl_sel)
        TBL_COLUMN: col_table[tbl_idx[9:0]] <= w_data[17:0];
        TBL_ROW:    row_table[tbl_idx[9:0]] <= w_data[17:0];
        TBL_SAMPLE: val_table[tbl_idx]      <= w_data[8:0];
        default:    ;
      endcase
    end
  end

  // -------- AXI4-Lite read path --------
  assign s_axi_arready = !s_axi_rvalid;

  always_ff @(posedge mclk or negedge rst_n) begin
    if (!rst_n) begin
      s_axi_rvalid <= 1'b0;
      s_axi_rdata  <= 32'h0000_0000;
      s_axi_rresp  <= RESP_OKAY;
    end else if (s_axi_arvalid && s_axi_arready) begin
      s_axi_rvalid <= 1'b1;
      s_axi_rresp  <= mapped({s_axi_araddr[7:2], 2'b00}) ? RESP_OKAY : RESP_SLVERR;
      case ({s_axi_araddr[7:2], 2'b00})
        REG_CTRL:      s_axi_rdata <= {27'h0, ctrl_narrow, 2'b00, ctrl_sel};
        REG_TBL_ADDR:  s_axi_rdata <= {18'h0, tbl_sel, 1'b0, tbl_idx};
        REG_GEN0_STAT: s_axi_rdata <= {9'h000, gen_status[0]};
        REG_GEN1_STAT: s_axi_rdata <= {9'h000, gen_status[1]};
        default:       s_axi_rdata <= 32'h0000_0000;
      endcase
    end else if (s_axi_rready) begin
      s_axi_rvalid <= 1'b0;
    end
  end

  // colour code from the zone codes; spare bit is the pattern select
  function automatic logic [8:0] colour_code(input logic sel, input logic narrow,
                                             input logic [4:0] rz, input logic [4:0] cz);
    logic [8:0] c;
    c = 9'h000;
    if (COL_ZONE_W + ROW_ZONE_W == 8) begin
      c = {sel, rz[3:0], cz[3:0]};
    end else if (ROW_ZONE_W == 5) begin
      c = {rz, cz[3:0]};
    end else begin
      c = {rz[3:0], cz};
    end
    if (narrow) begin
      c[3] = 1'b0;
    end
    return c;
  endfunction

  // -------- two independent generators --------
  for (genvar g = 0; g < 2; g++) begin : gen_unit
    logic [1:0]    sample_cnt;
    logic          step;
    vtp_col_word_t col_word;
    vtp_row_word_t row_word;
    vtp_fvh_t      fvh;
    vtp_fvh_t      fvh_q;
    logic [8:0]    code_word;
    logic [10:0]   val_addr;
    logic [8:0]    val_q;
    logic [1:0]    code_q;
    logic          sync_q;
    logic [10:0]   hword;
    logic [9:0]    lcnt;
    logic          cf_use;
    logic          cf_use_q;
    logic [9:0]    cf_val;
    logic [9:0]    cf_val_q;

    assign step = (sample_cnt == SC_SYNC);

    always_ff @(posedge mclk or negedge rst_n) begin
      if (!rst_n) begin
        sample_cnt <= 2'b00;
      end else if (restart[g]) begin
        sample_cnt <= 2'b00;
      end else begin
        sample_cnt <= sample_cnt + 2'b01;
      end
    end

    // column state: registered table output, next state feeds its address
    always_ff @(posedge mclk or negedge rst_n) begin
      if (!rst_n) begin
        col_word <= '0;
      end else if (restart[g]) begin
        col_word <= '0;
      end else if (step) begin
        col_word <= col_table[col_word.next_state];
      end
    end

    always_ff @(posedge mclk or negedge rst_n) begin
      if (!rst_n) begin
        row_word <= '0;
      end else if (restart[g]) begin
        row_word <= '0;
      end else if (step && col_word.end_of_line) begin
        row_word <= row_table[row_word.next_state];
      end
    end

    assign fvh = '{field:  row_word.odd_even_marker,
                   vblank: row_word.frame_blank_flag,
                   hblank: col_word.line_blank_flag};

    always_comb begin
      if (col_word.sync_word_insert) begin
        code_word = {6'h00, fvh};
      end else begin
        code_word = colour_code(ctrl_sel[g], ctrl_narrow,
                                row_word.row_zone_code, col_word.column_zone_code);
      end
    end
    assign val_addr = {code_word, sample_cnt};

    always_ff @(posedge mclk) begin
      val_q <= val_table[val_addr];
    end

    always_ff @(posedge mclk or negedge rst_n) begin
      if (!rst_n) begin
        fvh_q  <= '0;
        code_q <= SC_CB;
        sync_q <= 1'b0;
      end else begin
        fvh_q  <= fvh;
        code_q <= sample_cnt;
        sync_q <= col_word.sync_word_insert;
      end
    end

    // checkfield position counters
    always_ff @(posedge mclk or negedge rst_n) begin
      if (!rst_n) begin
        hword <= 11'h000;
      end else if (restart[g] || col_word.line_blank_flag) begin
        hword <= 11'h000;
      end else begin
        hword <= hword + 11'h001;
      end
    end

    always_ff @(posedge mclk or negedge rst_n) begin
      if (!rst_n) begin
        lcnt <= 10'h000;
      end else if (restart[g] || row_word.frame_blank_flag) begin
        lcnt <= 10'h000;
      end else if (step && col_word.end_of_line) begin
        lcnt <= lcnt + 10'h001;
      end
    end

    always_comb begin
      if (sample_cnt[0]) begin
        if (!row_word.odd_even_marker && lcnt == 10'h000 &&
            hword == 11'(CF_ACTIVE_WORDS - 1)) begin
          cf_val = CF_MARK;
        end else begin
          cf_val = (lcnt >= 10'(CF_HALF_LINES)) ? CF_B_LUMA : CF_A_LUMA;
        end
      end else begin
        cf_val = (lcnt >= 10'(CF_HALF_LINES)) ? CF_B_CHROMA : CF_A_CHROMA;
      end
    end

    // checkfield only in active video; bars keep sync and blanking
    assign cf_use = ctrl_sel[g] && !row_word.frame_blank_flag &&
                    !col_word.line_blank_flag && !col_word.sync_word_insert;

    always_ff @(posedge mclk or negedge rst_n) begin
      if (!rst_n) begin
        cf_use_q <= 1'b0;
        cf_val_q <= 10'h000;
      end else begin
        cf_use_q <= cf_use;
        cf_val_q <= cf_val;
      end
    end

    // output multiplexer
    always_ff @(posedge mclk or negedge rst_n) begin
      if (!rst_n) begin
        video_data[g] <= 10'h000;
        video_fvh[g]  <= '0;
      end else begin
        video_fvh[g] <= fvh_q;
        if (sync_q) begin
          case (code_q)
            SC_CB:   video_data[g] <= TRS_FIRST;
            SC_Y0:   video_data[g] <= TRS_ZERO;
            SC_CR:   video_data[g] <= TRS_ZERO;
            default: video_data[g] <= {val_q, val_q[0]};
          endcase
        end else if (cf_use_q) begin
          video_data[g] <= cf_val_q;
        end else begin
          video_data[g] <= {val_q, val_q[0]};
        end
      end
    end

    assign gen_status[g] = {fvh, row_word.next_state, col_word.next_state};
  end

endmodule

// ==== bench/vtp_gen_asserts.sv ====
// vtp_gen_asserts: stream and register-port checks for the pattern generator top.
// assumes loaded tables never place a 3ff word outside a timing reference sequence.
`timescale 1ns/100ps
module vtp_gen_checker (
  input wire logic                    mclk,          // clock
  input wire logic                    rst_n,         // reset
  input wire logic                    s_axi_awvalid, // aw valid
  input wire logic                    s_axi_awready, // aw ready
  input wire logic                    s_axi_wvalid,  // w valid
  input wire logic                    s_axi_wready,  // w ready
  input wire logic                    s_axi_bvalid,  // b valid
  input wire logic                    s_axi_arready, // ar ready
  input wire logic                    s_axi_rvalid,  // r valid
  input wire logic [1:0][9:0]         video_data,    // video words
  input wire vtp_pkg::vtp_fvh_t [1:0] video_fvh      // field/blank bits
);
  import vtp_pkg::*;
  default clocking cb @(posedge mclk);
  endclocking
  default disable iff (!rst_n);
  sequence s_pre0;
    video_data[0] == TRS_FIRST ##1 video_data[0] == TRS_ZERO ##1 video_data[0] == TRS_ZERO;
  endsequence
  sequence s_pre1;
    video_data[1] == TRS_FIRST ##1 video_data[1] == TRS_ZERO ##1 video_data[1] == TRS_ZERO;
  endsequence
  property p_trs_words0; video_data[0] == TRS_FIRST |-> s_pre0; endproperty
  a_trs_words0: assert property (p_trs_words0) else $error("gen0 preamble broken");
  property p_trs_words1; video_data[1] == TRS_FIRST |-> s_pre1; endproperty
  a_trs_words1: assert property (p_trs_words1) else $error("gen1 preamble broken");
  property p_trs_hblank0; video_data[0] == TRS_FIRST |-> video_fvh[0].hblank; endproperty
  a_trs_hblank0: assert property (p_trs_hblank0) else $error("preamble outside blank");
  property p_fvh_hold0; video_data[0] == TRS_FIRST |=> $stable(video_fvh[0]) [*3]; endproperty
  a_fvh_hold0: assert property (p_fvh_hold0) else $error("fvh moved in sequence");
  property p_status_lsb0; s_pre0 |=> video_data[0][1] == video_data[0][0]; endproperty
  a_status_lsb0: assert property (p_status_lsb0) else $error("status lsb not doubled");
  property p_write_busy; s_axi_bvalid |-> !s_axi_awready && !s_axi_wready; endproperty
  a_write_busy: assert property (p_write_busy) else $error("write taken while answering");
  property p_write_answer;
    s_axi_awvalid && s_axi_awready && s_axi_wvalid && s_axi_wready |-> ##[1:2] s_axi_bvalid;
  endproperty
  a_write_answer: assert property (p_write_answer) else $error("write answer late");
  property p_read_busy; s_axi_rvalid |-> !s_axi_arready; endproperty
  a_read_busy: assert property (p_read_busy) else $error("read taken while answering");
endmodule
bind vtp_pattern_gen vtp_gen_checker vtp_gen_checker_i (.mclk, .rst_n, .s_axi_awvalid,
  .s_axi_awready, .s_axi_wvalid, .s_axi_wready, .s_axi_bvalid, .s_axi_arready, .s_axi_rvalid,
  .video_data, .video_fvh);

// ==== bench/vtp_sink.sv ====
// vtp_sink: encoder stand-in that finds sync preambles and records each line.
// assumes one generator stream; keeps the last sixteen lines.
`timescale 1ns/100ps
module vtp_sink (
  input  wire logic        mclk,       // clock
  input  wire logic        rst_n,      // reset
  input  wire logic [9:0]  vdata,      // stream
  output logic      [15:0] lines,      // lines done
  output logic      [9:0]  rec [16][5] // status, four words
);
  logic [9:0] h1, h2, h3;
  logic [2:0] k;
  always @(posedge mclk or negedge rst_n) begin
    if (!rst_n) begin
      h1 <= 10'h000;
      h2 <= 10'h000;
      h3 <= 10'h000;
      k <= 3'h5;
      lines <= 16'h0000;
    end else begin
      h1 <= vdata;
      h2 <= h1;
      h3 <= h2;
      if (h3 == 10'h3ff && h2 == 10'h000 && h1 == 10'h000) begin
        rec[lines[3:0]][0] <= vdata;
        k <= 3'h1;
      end else if (k < 3'h5) begin
        rec[lines[3:0]][k] <= vdata;
        k <= k + 3'h1;
        lines <= lines + 16'(k == 3'h4);
      end
    end
  end
endmodule

// ==== bench/tb.sv ====
// tb: loads the tables over AXI4-Lite and judges both generator streams.
// assumes the hand-over register map; two sinks stand in for the encoder.
`timescale 1ns/100ps
`define CHK(nm, e, g) begin compares++; if ((g) !== (e)) begin miscompares++; \
  $display("MISMATCH %s exp %h got %h", nm, e, g); end end
module tb;
  import vtp_pkg::*;
  logic            mclk, rst_n, awvalid, wvalid, bready, arvalid, rready;
  logic            awready, wready, bvalid, arready, rvalid;
  logic [7:0]      awaddr, araddr;
  logic [31:0]     wdata, rdata;
  logic [3:0]      wstrb;
  logic [1:0]      bresp, rresp;
  logic [1:0][9:0] vdata;
  vtp_fvh_t [1:0]  vfvh;
  logic [15:0]     lines0, lines1;
  logic [9:0]      rec0 [16][5];
  logic [9:0]      rec1 [16][5];
  int              compares, miscompares;
  localparam logic [8:0] SMP [16] = '{9'h0, 9'h0, 9'h0, 9'h0, 9'h0, 9'h0, 9'h0, 9'h1a5,
    9'h0f0, 9'h101, 9'h0a0, 9'h0ff, 9'h0, 9'h0, 9'h0, 9'h1ec};
  vtp_pattern_gen #(.CF_ACTIVE_WORDS(4), .CF_HALF_LINES(2)) vtp_pattern_gen_i (
    .mclk(mclk), .rst_n(rst_n), .s_axi_awaddr(awaddr), .s_axi_awvalid(awvalid),
    .s_axi_awready(awready), .s_axi_wdata(wdata), .s_axi_wstrb(wstrb), .s_axi_wvalid(wvalid),
    .s_axi_wready(wready), .s_axi_bresp(bresp), .s_axi_bvalid(bvalid), .s_axi_bready(bready),
    .s_axi_araddr(araddr), .s_axi_arvalid(arvalid), .s_axi_arready(arready),
    .s_axi_rdata(rdata), .s_axi_rresp(rresp), .s_axi_rvalid(rvalid), .s_axi_rready(rready),
    .video_data(vdata), .video_fvh(vfvh));
  vtp_sink sink0 (.mclk(mclk), .rst_n(rst_n), .vdata(vdata[0]), .lines(lines0), .rec(rec0));
  vtp_sink sink1 (.mclk(mclk), .rst_n(rst_n), .vdata(vdata[1]), .lines(lines1), .rec(rec1));
  initial begin
    mclk = 1'b0;
    forever #25 mclk = ~mclk;
  end
  task automatic give_verdict();
    if (miscompares == 0 && compares > 0)
      $display("verification passed");
    else
      $display("verification failed");
    $finish;
  endtask
  task automatic axi_wr(input logic [7:0] a, input logic [31:0] d, input logic [3:0] s,
                        input logic [1:0] er);
    logic aw_ok, w_ok;
    @(posedge mclk);
    aw_ok = 1'b0;
    w_ok = 1'b0;
    awaddr <= a;
    wdata <= d;
    wstrb <= s;
    awvalid <= 1'b1;
    wvalid <= 1'b1;
    bready <= 1'b1;
    while (1) begin
      @(posedge mclk);
      if (!aw_ok && awready) begin
        aw_ok = 1'b1;
        awvalid <= 1'b0;
      end
      if (!w_ok && wready) begin
        w_ok = 1'b1;
        wvalid <= 1'b0;
      end
      if (bvalid) break;
    end
    bready <= 1'b0;
    `CHK("bresp", er, bresp)
  endtask
  task automatic axi_rd(input logic [7:0] a, output logic [31:0] d, output logic [1:0] r);
    logic ar_ok;
    @(posedge mclk);
    ar_ok = 1'b0;
    araddr <= a;
    arvalid <= 1'b1;
    rready <= 1'b1;
    while (1) begin
      @(posedge mclk);
      if (!ar_ok && arready) begin
        ar_ok = 1'b1;
        arvalid <= 1'b0;
      end
      if (rvalid) break;
    end
    rready <= 1'b0;
    d = rdata;
    r = rresp;
  endtask
  task automatic tbl_at(input logic [1:0] t, input logic [10:0] ix);
    axi_wr(REG_TBL_ADDR, (32'(t) << TBL_SEL_LSB) | 32'(ix), 4'hf, RESP_OKAY);
  endtask
  task automatic wait_lines(input int n);
    int g = 0;
    int base = lines0;
    while (lines0 - base < n && g < 400) begin
      @(posedge mclk);
      g++;
    end
    `CHK("lines seen", 1, int'(lines0 - base >= n))
  endtask
  task automatic chk_words(input logic [9:0] r [16][5], input int ix, input logic [9:0] e [4]);
    for (int k = 0; k < 4; k++) `CHK("active word", e[k], r[ix % 16][k + 1])
  endtask
  task automatic t_regs();
    logic [31:0] d;
    logic [1:0] r;
    axi_rd(REG_CTRL, d, r);
    `CHK("ctrl reset", 32'h0, d)
    axi_rd(8'h14, d, r);
    `CHK("unmapped rresp", RESP_SLVERR, r)
    `CHK("unmapped rdata", 32'h0, d)
    axi_wr(8'h14, 32'h1f, 4'hf, RESP_SLVERR);
    axi_wr(REG_CTRL, 32'h13, 4'h0, RESP_OKAY);
    axi_rd(REG_CTRL, d, r);
    `CHK("ctrl no strobe", 32'h0, d)
    axi_wr(REG_CTRL, 32'h13, 4'hf, RESP_OKAY);
    axi_rd(REG_CTRL, d, r);
    `CHK("ctrl", 32'h13, d)
    axi_wr(REG_CTRL, 32'h0, 4'hf, RESP_OKAY);
    axi_rd(REG_TBL_DATA, d, r);
    `CHK("tbl data read", 32'h0, d)
  endtask
  task automatic t_load();
    tbl_at(TBL_COLUMN, 11'h000);
    axi_wr(REG_TBL_DATA, 32'h28001, 4'hf, RESP_OKAY);
    axi_wr(REG_TBL_DATA, 32'h12800, 4'hf, RESP_OKAY);
    tbl_at(TBL_ROW, 11'h000);
    for (int i = 0; i < 4; i++) axi_wr(REG_TBL_DATA, (i == 0) ? 32'h08001 : 32'((i + 1) % 4),
      4'hf, RESP_OKAY);
    tbl_at(TBL_SAMPLE, 11'h000);
    for (int i = 0; i < 16; i++) axi_wr(REG_TBL_DATA, 32'(SMP[i]), 4'hf, RESP_OKAY);
    tbl_at(TBL_SAMPLE, 11'h028);
    for (int i = 0; i < 4; i++) axi_wr(REG_TBL_DATA, 32'h055, 4'hf, RESP_OKAY);
    tbl_at(TBL_SAMPLE, 11'h428);
    for (int i = 0; i < 4; i++) axi_wr(REG_TBL_DATA, 32'h000, 4'hf, RESP_OKAY);
    axi_wr(REG_CTRL, 32'h0c, 4'hf, RESP_OKAY);
  endtask
  task automatic t_bars();
    int nb = 0;
    int na = 0;
    wait_lines(6);
    for (int i = 1; i <= 4; i++) begin
      chk_words(rec0, lines0 - i, '{10'h0ab, 10'h0ab, 10'h0ab, 10'h0ab});
      chk_words(rec1, lines1 - i, '{10'h0ab, 10'h0ab, 10'h0ab, 10'h0ab});
      nb += int'(rec0[(lines0 - i) % 16][0] === 10'h3d8);
      na += int'(rec0[(lines0 - i) % 16][0] === 10'h34b);
    end
    `CHK("blank lines per frame", 1, nb)
    `CHK("status words", 3, na)
  endtask
  task automatic t_narrow();
    axi_wr(REG_CTRL, 32'h10, 4'hf, RESP_OKAY);
    // one extra line: the line in flight at the write may still carry the old palette
    wait_lines(5);
    for (int i = 1; i <= 4; i++)
      chk_words(rec0, lines0 - i, '{10'h1e0, 10'h203, 10'h140, 10'h1ff});
  endtask
  task automatic t_check();
    int j;
    int found = 0;
    axi_wr(REG_CTRL, 32'h01, 4'hf, RESP_OKAY);
    wait_lines(9);
    for (int i = 1; i <= 4; i++) begin
      j = lines0 - 8 + i;
      if (rec0[j % 16][4] === CF_MARK) begin
        found++;
        `CHK("status before", 10'h3d8, rec0[(j - 1) % 16][0])
        `CHK("status", 10'h34b, rec0[j % 16][0])
        chk_words(rec0, j - 1, '{10'h000, 10'h000, 10'h000, 10'h000});
        chk_words(rec0, j, '{CF_A_CHROMA, CF_A_LUMA, CF_A_CHROMA, CF_MARK});
        chk_words(rec0, j + 1, '{CF_A_CHROMA, CF_A_LUMA, CF_A_CHROMA, CF_A_LUMA});
        chk_words(rec0, j + 2, '{CF_B_CHROMA, CF_B_LUMA, CF_B_CHROMA, CF_B_LUMA});
      end
    end
    `CHK("marked lines", 1, found)
    chk_words(rec1, lines1 - 1, '{10'h0ab, 10'h0ab, 10'h0ab, 10'h0ab});
  endtask
  initial begin
    rst_n = 1'b0;
    {awvalid, wvalid, bready, arvalid, rready} = 5'h00;
    awaddr = 8'h00;
    araddr = 8'h00;
    wdata = 32'h0;
    wstrb = 4'hf;
    compares = 0;
    miscompares = 0;
    repeat (6) @(posedge mclk);
    rst_n <= 1'b1;
    t_regs();
    t_load();
    t_bars();
    t_narrow();
    t_check();
    give_verdict();
  end
  initial begin
    repeat (20000) @(posedge mclk);
    miscompares++;
    give_verdict();
  end
endmodule
